// file: logic/jib_regs.vh
// Constants for the board-test identity register and boundary scan chain
`ifndef JIB_REGS_VH
`define JIB_REGS_VH
`define JIB_ID_LEN 32
`define JIB_ID_VER_MSB 31
`define JIB_ID_VER_LSB 28
`define JIB_ID_PART_MSB 27
`define JIB_ID_PART_LSB 22
`define JIB_ID_SEQ_MSB 21
`define JIB_ID_SEQ_LSB 12
`define JIB_ID_MFR_MSB 11
`define JIB_ID_MFR_LSB 1
`define JIB_ID_MARK 1'h1
`define JIB_IR_LEN 4
`define JIB_OP_EXTEST 4'h0
`define JIB_OP_SAMPLE 4'h1
`define JIB_OP_IDENT 4'h2
`define JIB_OP_BYPASS 4'hF
`define JIB_IR_CAPTURE 4'h1
`define JIB_CHAIN_LEN 130
`define JIB_POS_SAB_CTRL 0
`define JIB_POS_SAB_DATA 1
`define JIB_POS_IRQ_BASE 2
`define JIB_POS_DHI_CTRL 15
`define JIB_POS_DLO_CTRL 28
`define JIB_POS_AHI_CTRL 35
`define JIB_POS_ALO_CTRL 45
`define JIB_POS_BUS_GRANT 52
`define JIB_POS_REST 53
`define JIB_REST_LEN 77
`endif

// file: logic/jib_sync.v
// Two-stage synchroniser for signals entering the ref_clk domain
`timescale 1ns/100ps
module jib_sync #(
    parameter W = 1
) (
    input wire ref_clk,
    input wire rst,
    input wire [W-1:0] din,
    output reg [W-1:0] dout
);
    reg [W-1:0] stage1_r;

    always @(posedge ref_clk) begin
        if (rst) begin
            stage1_r <= {W{1'b0}};
            dout <= {W{1'b0}};
        end else begin
            stage1_r <= din;
            dout <= stage1_r;
        end
    end
endmodule

// file: logic/jib_tap_core.v
// Test access port with identity register and boundary scan chain
`timescale 1ns/100ps
`include "jib_regs.vh"

module jib_tap_core #(
    // Identity field defaults are arbitrary values
    parameter [3:0] ID_VERSION = 4'h3,
    parameter [5:0] ID_PART = 6'h15,
    parameter [9:0] ID_SEQUENCE = 10'h2C6,
    parameter [10:0] ID_MAKER = 11'h4A9
) (
    input wire ref_clk,
    input wire rst,
    input wire tck,
    input wire tms,
    input wire tdi,
    input wire trstN,
    output reg tdo,
    output reg tdoOe,
    input wire [3:0] extInterrupt,
    input wire busGrantIn,
    input wire serialAudioBLineFourIn,
    output wire serialAudioBLineFourOut,
    output wire serialAudioBLineFourOe,
    input wire [23:0] dataBusIn,
    output wire [23:0] dataBusOut,
    output wire [23:0] dataBusOe,
    output wire [17:0] addrOut,
    output wire [17:0] addrOe,
    input wire [`JIB_REST_LEN-1:0] otherCellIn,
    output wire [`JIB_REST_LEN-1:0] otherCellOut,
    output reg boundaryDrive
);
    localparam N = `JIB_CHAIN_LEN;
    localparam [15:0] S_RESET = 16'h0001;
    localparam [15:0] S_IDLE = 16'h0002;
    localparam [15:0] S_SELDR = 16'h0004;
    localparam [15:0] S_CAPDR = 16'h0008;
    localparam [15:0] S_SHDR = 16'h0010;
    localparam [15:0] S_EX1DR = 16'h0020;
    localparam [15:0] S_PAUDR = 16'h0040;
    localparam [15:0] S_EX2DR = 16'h0080;
    localparam [15:0] S_UPDDR = 16'h0100;
    localparam [15:0] S_SELIR = 16'h0200;
    localparam [15:0] S_CAPIR = 16'h0400;
    localparam [15:0] S_SHIR = 16'h0800;
    localparam [15:0] S_EX1IR = 16'h1000;
    localparam [15:0] S_PAUIR = 16'h2000;
    localparam [15:0] S_EX2IR = 16'h4000;
    localparam [15:0] S_UPDIR = 16'h8000;

    // Fixed identity word; bit 0 is always one
    wire [`JIB_ID_LEN-1:0] idWord = {ID_VERSION, ID_PART, ID_SEQUENCE, ID_MAKER,
        `JIB_ID_MARK};

    // Chain position of each data-bus and address line
    function integer dataPos;
        input integer i;
        begin
            if (i >= 15)
                dataPos = 6 + (23 - i);
            else if (i >= 13)
                dataPos = 16 + (14 - i);
            else if (i >= 3)
                dataPos = 18 + (12 - i);
            else
                dataPos = 29 + (2 - i);
        end
    endfunction

    function integer addrPos;
        input integer i;
        begin
            if (i >= 15)
                addrPos = 32 + (17 - i);
            else if (i >= 6)
                addrPos = 36 + (14 - i);
            else
                addrPos = 46 + (5 - i);
        end
    endfunction

    wire [3:0] tapSync;
    wire [106:0] pinSync;
    jib_sync #(.W(4)) uTapSync (
        .ref_clk(ref_clk),
        .rst(rst),
        .din({tck, tms, tdi, trstN}),
        .dout(tapSync)
    );
    jib_sync #(.W(107)) uPinSync (
        .ref_clk(ref_clk),
        .rst(rst),
        .din({otherCellIn, dataBusIn, serialAudioBLineFourIn, busGrantIn, extInterrupt}),
        .dout(pinSync)
    );
    wire tckS = tapSync[3];
    wire tmsS = tapSync[2];
    wire tdiS = tapSync[1];
    wire trstS = ~tapSync[0];

    reg tckPrev_r;
    reg [15:0] state_r;
    reg [15:0] state_nxt;
    reg [`JIB_IR_LEN-1:0] irShift_r;
    reg [`JIB_IR_LEN-1:0] instr_r;
    reg [N-1:0] boundaryScanChain_r;
    reg [N-1:0] boundaryScanChain_nxt;
    reg [N-1:0] update_r;
    wire [N-1:0] capture;
    wire tckRise = tckS & ~tckPrev_r;
    wire tckFall = ~tckS & tckPrev_r;
    wire selId = (instr_r == `JIB_OP_IDENT);
    wire selChain = (instr_r == `JIB_OP_EXTEST) || (instr_r == `JIB_OP_SAMPLE);

    // Capture vector: pin data for input and bidirectional cells, held value elsewhere
    genvar g;
    generate
        for (g = 0; g < 24; g = g + 1) begin : gData
            assign capture[dataPos(g)] = pinSync[6 + g];
            assign dataBusOut[g] = update_r[dataPos(g)];
            assign dataBusOe[g] = (g >= 13) ? update_r[`JIB_POS_DHI_CTRL] :
                update_r[`JIB_POS_DLO_CTRL];
        end
        for (g = 0; g < 18; g = g + 1) begin : gAddr
            assign capture[addrPos(g)] = update_r[addrPos(g)];
            assign addrOut[g] = update_r[addrPos(g)];
            assign addrOe[g] = (g >= 9) ? update_r[`JIB_POS_AHI_CTRL] :
                update_r[`JIB_POS_ALO_CTRL];
        end
        for (g = 0; g < 4; g = g + 1) begin : gIrq
            assign capture[`JIB_POS_IRQ_BASE + g] = pinSync[g];
        end
        for (g = 0; g < `JIB_REST_LEN; g = g + 1) begin : gRest
            assign capture[`JIB_POS_REST + g] = pinSync[30 + g];
            assign otherCellOut[g] = update_r[`JIB_POS_REST + g];
        end
    endgenerate

    assign capture[`JIB_POS_SAB_CTRL] = update_r[`JIB_POS_SAB_CTRL];
    assign capture[`JIB_POS_SAB_DATA] = pinSync[5];
    assign capture[`JIB_POS_DHI_CTRL] = update_r[`JIB_POS_DHI_CTRL];
    assign capture[`JIB_POS_DLO_CTRL] = update_r[`JIB_POS_DLO_CTRL];
    assign capture[`JIB_POS_AHI_CTRL] = update_r[`JIB_POS_AHI_CTRL];
    assign capture[`JIB_POS_ALO_CTRL] = update_r[`JIB_POS_ALO_CTRL];
    assign capture[`JIB_POS_BUS_GRANT] = pinSync[4];

    assign serialAudioBLineFourOut = update_r[`JIB_POS_SAB_DATA];
    assign serialAudioBLineFourOe = update_r[`JIB_POS_SAB_CTRL];

    // TAP controller next state
    always @* begin
        case (state_r)
            S_RESET: state_nxt = tmsS ? S_RESET : S_IDLE;
            S_IDLE: state_nxt = tmsS ? S_SELDR : S_IDLE;
            S_SELDR: state_nxt = tmsS ? S_SELIR : S_CAPDR;
            S_CAPDR: state_nxt = tmsS ? S_EX1DR : S_SHDR;
            S_SHDR: state_nxt = tmsS ? S_EX1DR : S_SHDR;
            S_EX1DR: state_nxt = tmsS ? S_UPDDR : S_PAUDR;
            S_PAUDR: state_nxt = tmsS ? S_EX2DR : S_PAUDR;
            S_EX2DR: state_nxt = tmsS ? S_UPDDR : S_SHDR;
            S_UPDDR: state_nxt = tmsS ? S_SELDR : S_IDLE;
            S_SELIR: state_nxt = tmsS ? S_RESET : S_CAPIR;
            S_CAPIR: state_nxt = tmsS ? S_EX1IR : S_SHIR;
            S_SHIR: state_nxt = tmsS ? S_EX1IR : S_SHIR;
            S_EX1IR: state_nxt = tmsS ? S_UPDIR : S_PAUIR;
            S_PAUIR: state_nxt = tmsS ? S_EX2IR : S_PAUIR;
            S_EX2IR: state_nxt = tmsS ? S_UPDIR : S_SHIR;
            S_UPDIR: state_nxt = tmsS ? S_SELDR : S_IDLE;
            default: state_nxt = S_RESET;
        endcase
    end

    // Data path capture and shift; the identity register only ever loads the fixed word
    always @* begin
        boundaryScanChain_nxt = boundaryScanChain_r;
        if (state_r == S_CAPDR) begin
            if (selId)
                boundaryScanChain_nxt[`JIB_ID_LEN-1:0] = idWord;
            else if (selChain)
                boundaryScanChain_nxt = capture;
            else
                boundaryScanChain_nxt[0] = 1'b0;
        end else if (state_r == S_SHDR) begin
            if (selId)
                boundaryScanChain_nxt[`JIB_ID_LEN-1:0] =
                    {tdiS, boundaryScanChain_r[`JIB_ID_LEN-1:1]};
            else if (selChain)
                boundaryScanChain_nxt = {tdiS, boundaryScanChain_r[N-1:1]};
            else
                boundaryScanChain_nxt[0] = tdiS;
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            tckPrev_r <= 1'b0;
            state_r <= S_RESET;
            irShift_r <= `JIB_IR_CAPTURE;
            instr_r <= `JIB_OP_IDENT;
            boundaryScanChain_r <= {N{1'b0}};
            update_r <= {N{1'b0}};
            tdo <= 1'b0;
            tdoOe <= 1'b0;
            boundaryDrive <= 1'b0;
        end else begin
            tckPrev_r <= tckS;
            boundaryDrive <= (instr_r == `JIB_OP_EXTEST);
            if (trstS) begin
                state_r <= S_RESET;
                instr_r <= `JIB_OP_IDENT;
                tdoOe <= 1'b0;
            end else if (tckRise) begin
                state_r <= state_nxt;
                boundaryScanChain_r <= boundaryScanChain_nxt;
                if (state_r == S_RESET)
                    instr_r <= `JIB_OP_IDENT;
                if (state_r == S_CAPIR)
                    irShift_r <= `JIB_IR_CAPTURE;
                if (state_r == S_SHIR)
                    irShift_r <= {tdiS, irShift_r[`JIB_IR_LEN-1:1]};
                if (state_r == S_UPDIR)
                    instr_r <= irShift_r;
                if (state_r == S_UPDDR && selChain)
                    update_r <= boundaryScanChain_r;
            end else if (tckFall) begin
                // Output changes on the falling test clock edge, LSB first
                tdoOe <= (state_r == S_SHDR) || (state_r == S_SHIR);
                tdo <= (state_r == S_SHIR) ? irShift_r[0] : boundaryScanChain_r[0];
            end
        end
    end
endmodule

// file: sim/jib_tap_chk.sv
// Assertion checker for the board-test port
`timescale 1ns/100ps
module jib_tap_chk (
    input ref_clk,
    input rst,
    input tck,
    input trstN,
    input tdo,
    input tdoOe,
    input boundaryDrive,
    input serialAudioBLineFourOe,
    input [23:0] dataBusOe,
    input [17:0] addrOe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_trst_held;
        !trstN [*4];
    endsequence
    property p_dhi_grp;
        dataBusOe[23:13] == {11{dataBusOe[23]}};
    endproperty
    property p_dlo_grp;
        dataBusOe[12:0] == {13{dataBusOe[0]}};
    endproperty
    property p_ahi_grp;
        addrOe[17:9] == {9{addrOe[17]}};
    endproperty
    property p_alo_grp;
        addrOe[8:0] == {9{addrOe[0]}};
    endproperty
    property p_rst_port;
        $fell(rst) |-> !tdo && !tdoOe && !boundaryDrive;
    endproperty
    property p_rst_oe;
        $fell(rst) |-> !serialAudioBLineFourOe && dataBusOe == 24'h0 && addrOe == 18'h0;
    endproperty
    property p_tdo_hold;
        tck [*6] |-> $stable(tdo) && $stable(tdoOe);
    endproperty
    property p_trst;
        s_trst_held |-> ##[0:6] !boundaryDrive;
    endproperty
    a_dhi_grp: assert property (p_dhi_grp) else $error("data enable high group split");
    a_dlo_grp: assert property (p_dlo_grp) else $error("data enable low group split");
    a_ahi_grp: assert property (p_ahi_grp) else $error("addr enable high group split");
    a_alo_grp: assert property (p_alo_grp) else $error("addr enable low group split");
    a_rst_port: assert property (p_rst_port) else $error("test port busy after reset");
    a_rst_oe: assert property (p_rst_oe) else $error("pin enables set after reset");
    a_tdo_hold: assert property (p_tdo_hold) else $error("tdo moved with tck high");
    a_trst: assert property (p_trst) else $error("test reset left drive on");
endmodule
bind jib_tap_core jib_tap_chk jib_tap_chk_i (.ref_clk, .rst, .tck, .trstN, .tdo, .tdoOe,
    .boundaryDrive, .serialAudioBLineFourOe, .dataBusOe, .addrOe);

// file: sim/jib_tester.sv
// Board tester model driving the test port
`timescale 1ns/100ps
module jib_tester (
    input wire ref_clk,
    input wire tdo,
    output reg tck,
    output reg tms,
    output reg tdi
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // One test clock of 160 ns; tdo taken at the rise
    task bit_step(input m, input d, output q);
        begin
            tms <= m;
            tdi <= d;
            repeat (8) @(posedge ref_clk);
            tck <= 1'b1;
            q = tdo;
            repeat (8) @(posedge ref_clk);
            tck <= 1'b0;
        end
    endtask
    // State walk, tms bits LSB first, data line toggling
    task walk(input [7:0] s, input integer n);
        reg q;
        integer i;
        begin
            for (i = 0; i < n; i++) bit_step(s[i], ~tdi, q);
        end
    endtask
    // Scan from idle back to idle, LSB first
    task scan(input ir, input integer n, input [129:0] din, output [129:0] dout);
        reg q;
        integer i;
        begin
            dout = 130'h0;
            walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
            for (i = 0; i < n; i++) begin
                bit_step(i == n - 1, din[i], q);
                dout[i] = q;
            end
            walk(8'h01, 2);
        end
    endtask
endmodule

// file: sim/jib_tap_core_tb.sv
// Self-checking bench for the board-test port
`timescale 1ns/100ps
module jib_tap_core_tb;
    // Identity field values are arbitrary
    localparam [31:0] IDW = {4'h5, 6'h2A, 10'h135, 11'h2B7, 1'b1};
    reg ref_clk = 1'b0;
    reg rst = 1'b1;
    reg trstN = 1'b1;
    reg [3:0] extInterrupt = 4'h0;
    reg busGrantIn = 1'b0;
    reg serialAudioBLineFourIn = 1'b0;
    reg [23:0] dataBusIn = 24'h0;
    reg [76:0] otherCellIn = 77'h0;
    wire tck, tms, tdi, tdo, tdoOe, sabOut, sabOe, boundaryDrive;
    wire [23:0] dataBusOut, dataBusOe;
    wire [17:0] addrOut, addrOe;
    wire [76:0] otherCellOut;
    reg [129:0] got, want;
    integer failures = 0;
    integer checkCount = 0;
    integer k;
    always #5 ref_clk = ~ref_clk;
    // Undriven tdo line shows the inverse of its last value
    jib_tester jib_tester_i (.ref_clk, .tdo(tdoOe ? tdo : ~tdo), .tck, .tms, .tdi);
    jib_tap_core #(.ID_VERSION(4'h5), .ID_PART(6'h2A), .ID_SEQUENCE(10'h135),
        .ID_MAKER(11'h2B7)) jib_tap_core_i (.ref_clk, .rst, .tck, .tms, .tdi, .trstN, .tdo,
        .tdoOe, .extInterrupt, .busGrantIn, .serialAudioBLineFourIn,
        .serialAudioBLineFourOut(sabOut), .serialAudioBLineFourOe(sabOe), .dataBusIn,
        .dataBusOut, .dataBusOe, .addrOut, .addrOe, .otherCellIn, .otherCellOut,
        .boundaryDrive);
    function integer dpos(input integer j);
        dpos = j > 14 ? 29 - j : (j > 2 ? 30 - j : 31 - j);
    endfunction
    function integer apos(input integer j);
        apos = j > 14 ? 49 - j : (j > 5 ? 50 - j : 51 - j);
    endfunction
    task tallyAndFinish;
        begin
            $display("Checks %0d, mismatches %0d", checkCount, failures);
            if (failures == 0 && checkCount > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    task chk(input [129:0] g, input [129:0] w);
        begin
            checkCount = checkCount + 1;
            if (g !== w) begin
                failures = failures + 1;
                $display("ERROR %0t got %h want %h", $time, g, w);
            end
        end
    endtask
    task t_ident;
        begin
            jib_tester_i.scan(0, 32, 130'h0, got);
            chk(got[31:0], IDW);
            jib_tester_i.scan(0, 32, ~130'h0, got);
            chk(got[31:0], IDW);
            jib_tester_i.scan(1, 4, 130'h2, got);
            chk(got[3:0], 4'h1);
            jib_tester_i.scan(0, 32, 130'h0, got);
            chk(got[31:0], IDW);
        end
    endtask
    // Bypass path: one cell that captures zero
    task t_bypass;
        begin
            jib_tester_i.scan(1, 4, 130'hF, got);
            chk(got[3:0], 4'h1);
            jib_tester_i.scan(0, 8, 130'hA5, got);
            chk(got[7:0], 8'h4A);
        end
    endtask
    task t_sample;
        begin
            jib_tester_i.scan(1, 4, 130'h1, got);
            extInterrupt <= 4'h9;
            busGrantIn <= 1'b1;
            serialAudioBLineFourIn <= 1'b1;
            dataBusIn <= 24'hA5C381;
            otherCellIn <= {11{7'h4B}};
            jib_tester_i.scan(0, 130, 130'h0, got);
            want = {{11{7'h4B}}, 53'h0};
            want[5:0] = 6'h26;
            want[52] = 1'b1;
            for (k = 0; k < 24; k++) want[dpos(k)] = dataBusIn[k];
            chk(got, want);
            chk(boundaryDrive, 1'b0);
        end
    endtask
    task t_extest(input [129:0] v, input s);
        begin
            {v[0], v[15], v[35], v[28], v[45]} = {s, s, s, ~s, ~s};
            jib_tester_i.scan(1, 4, 130'h0, got);
            jib_tester_i.scan(0, 130, v, got);
            chk(boundaryDrive, 1'b1);
            chk({sabOe, sabOut}, {v[0], v[1]});
            chk({dataBusOe[23], dataBusOe[0], addrOe[17], addrOe[0]}, {s, ~s, s, ~s});
            for (k = 0; k < 24; k++) chk(dataBusOut[k], v[dpos(k)]);
            for (k = 0; k < 18; k++) chk(addrOut[k], v[apos(k)]);
            chk(otherCellOut, v[129:53]);
        end
    endtask
    task t_trst;
        begin
            trstN <= 1'b0;
            repeat (5) @(posedge ref_clk);
            trstN <= 1'b1;
            repeat (4) @(posedge ref_clk);
            chk(boundaryDrive, 1'b0);
            jib_tester_i.walk(8'h0, 1);
            jib_tester_i.scan(0, 32, 130'h0, got);
            chk(got[31:0], IDW);
        end
    endtask
    initial begin
        repeat (50000) @(posedge ref_clk);
        failures = failures + 1;
        tallyAndFinish;
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        jib_tester_i.walk(8'h0, 1);
        t_ident;
        t_bypass;
        t_sample;
        t_extest({65{2'b10}}, 1'b1);
        t_extest({65{2'b01}}, 1'b0);
        t_trst;
        tallyAndFinish;
    end
endmodule
